/* File: design/tiep_defs.vh */
`ifndef TIEP_DEFS_VH
`define TIEP_DEFS_VH
// Notes on behaviour
// R1 - Every input channel is checked for receiver link errors and line-code errors.
// R2 - Sender embeds a CRC per word; the device recomputes and compares it.
// R3 - Error counter advances once per bunch tick with any error on any channel.
// R4 - Per-channel error kind flags and last error tick kept in readable registers.
// R5 - Data of an event with a detected error are forced to zero before use.
// R6 - All four channels of one quad run at one common rate, 11.2 or 12.8 Gb/s.
// R7 - The two processing units handle their own input independently and concurrently.
// R8 - Real-time result is one pass bit per algorithm plus one overflow bit.
// R9 - Results leave on 32 low-latency differential output lines.
// R10 - A level-1 accept captures all real-time output data for readout; one arriving while a readout is still being sent is ignored.
// R11 - Input capture for readout is either error-conditional or fixed by software.
// R12 - Slices read out per event are programmable, at most 3.
// R13 - Timing source sends clock and commands on two separate pairs.
// R14 - In replay mode received input is ignored; scrolling memories supply the input.
// R15 - Replayed data enter at the algorithm input, replacing external data there.
// R16 - Optionally the output comes from a second, separate scrolling memory.
// R17 - Replay always uses input memories; output memory use stays optional.
// R18 - Replay applies to all channels together, never to a subset.
// R19 - Replay select and memory loading are done over the register bus.
// R20 - Each scrolling memory is 256 words deep.
// R21 - Error counts are readable and resettable over the register bus.
// R22 - Error counter saturates at its maximum instead of wrapping.

// ****************************************
// Sizes
// ****************************************
`define TIEP_NCH          4
`define TIEP_CH_W         32
`define TIEP_CRC_W        8
`define TIEP_CRC_POLY     8'h07
`define TIEP_MEM_DEPTH    256
`define TIEP_MEM_AW       8
`define TIEP_MAX_SLICES   2'h3
`define TIEP_OUT_W        32

// ****************************************
// Register offsets
// ****************************************
`define TIEP_REG_CTRL     6'h00
`define TIEP_REG_STATUS   6'h04
`define TIEP_REG_ERRCNT   6'h08
`define TIEP_REG_ERRDET   6'h0C
`define TIEP_REG_ERRTICK  6'h10
`define TIEP_REG_MEMADDR  6'h14
`define TIEP_REG_MEMDATA  6'h18

// ****************************************
// Control fields and reset values
// ****************************************
`define TIEP_CTRL_REPLAY   0
`define TIEP_CTRL_OUTMEM   1
`define TIEP_CTRL_COND     2
`define TIEP_CTRL_INFIX    3
`define TIEP_CTRL_SLC_LO   4
`define TIEP_CTRL_SLC_HI   5
`define TIEP_CTRL_RATE     6
`define TIEP_CTRL_W        7
`define TIEP_CTRL_RESET    7'h10
`define TIEP_LANE_OUT      3'h4
`endif

/* File: design/tiep_scroll_mem.v */
`timescale 1ns/1ps
`include "tiep_defs.vh"
module tiep_scroll_mem #(
    parameter WIDTH = 128
) (
    input  wire                       clk,
    input  wire                       nrst,
    input  wire                       wr_en,
    input  wire [`TIEP_MEM_AW-1:0]    wr_addr,
    input  wire [2:0]                 wr_lane,
    input  wire [31:0]                wr_data,
    input  wire                       restart,
    input  wire                       advance,
    output reg  [WIDTH-1:0]           rd_data,
    output reg  [`TIEP_MEM_AW-1:0]    rd_ptr
);
    localparam LANES = WIDTH / 32;

    reg [WIDTH-1:0] mem [0:`TIEP_MEM_DEPTH-1]; // [R20]

    always @(posedge clk) begin
        if (wr_en && (wr_lane < LANES)) begin
            mem[wr_addr][wr_lane*32 +: 32] <= wr_data; // [R19]
        end
    end

    // ****************************************
    // Scrolling read pointer
    // ****************************************
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rd_ptr  <= {`TIEP_MEM_AW{1'b0}};
            rd_data <= {WIDTH{1'b0}};
        end else if (restart) begin
            rd_ptr  <= {`TIEP_MEM_AW{1'b0}};
            rd_data <= {WIDTH{1'b0}};
        end else if (advance) begin
            rd_ptr  <= rd_ptr + 1'b1;
            rd_data <= mem[rd_ptr];
        end
    end
endmodule

/* File: design/tiep_err_cnt.v */
`timescale 1ns/1ps
module tiep_err_cnt (
    input  wire        clk,
    input  wire        nrst,
    input  wire        clear,
    input  wire        inc,
    output reg  [31:0] count
);
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            count <= 32'h00000000;
        end else if (clear) begin
            count <= 32'h00000000; // [R21]
        end else if (inc && (count != 32'hFFFFFFFF)) begin
            count <= count + 32'h00000001; // [R3] [R22]
        end
    end
endmodule

/* File: design/tiep_top.v */
// The placing of the registers and the Wishbone slave port were left to the implementer.
`timescale 1ns/1ps
`include "tiep_defs.vh"
module tiep_top (
    input  wire                              CLK,
    input  wire                              NRST,
    input  wire [31:0]                       WB_ADR_I,
    input  wire [31:0]                       WB_DAT_I,
    input  wire [3:0]                        WB_SEL_I,
    input  wire                              WB_WE_I,
    input  wire                              WB_CYC_I,
    input  wire                              WB_STB_I,
    output reg  [31:0]                       WB_DAT_O,
    output reg                               WB_ACK_O,
    input  wire [`TIEP_NCH*`TIEP_CH_W-1:0]   RX_DATA,
    input  wire [`TIEP_NCH*`TIEP_CRC_W-1:0]  RX_CRC,
    input  wire [`TIEP_NCH-1:0]              RX_LINK_ERR,
    input  wire [`TIEP_NCH-1:0]              RX_CODE_ERR,
    output reg                               QUAD_RATE_SEL,
    output reg  [`TIEP_NCH*`TIEP_CH_W-1:0]   ALG_IN_DATA,
    output reg  [1:0]                        UNIT_ERR,
    input  wire [30:0]                       ALG_PASS,
    input  wire                              ALG_OVERFLOW,
    output reg  [`TIEP_OUT_W-1:0]            CTP_OUT,
    input  wire                              LEVEL1_ACCEPT,
    output reg  [31:0]                       READOUT_DATA,
    output reg                               READOUT_VALID,
    output reg                               READOUT_LAST
);
    localparam NCH   = `TIEP_NCH;
    localparam CW    = `TIEP_CH_W;
    localparam INW   = NCH * CW;
    localparam S_IDLE = 1'b0;
    localparam S_SEND = 1'b1;

    // ****************************************
    // Helper functions
    // ****************************************
    function [7:0] crc8;
        input [31:0] d;
        integer i;
        reg [7:0] c;
        begin
            c = 8'h00;
            for (i = 31; i >= 0; i = i - 1) begin
                if (c[7] ^ d[i]) begin
                    c = {c[6:0], 1'b0} ^ `TIEP_CRC_POLY;
                end else begin
                    c = {c[6:0], 1'b0};
                end
            end
            crc8 = c;
        end
    endfunction

    function [1:0] clamp_slices;
        input [1:0] v;
        begin
            if (v == 2'h0) begin
                clamp_slices = 2'h1;
            end else begin
                clamp_slices = v;
            end
        end
    endfunction

    // ****************************************
    // Registers
    // ****************************************
    reg  [`TIEP_CTRL_W-1:0]  ctrl;
    reg  [11:0]              err_det;
    reg  [31:0]              err_tick;
    reg  [31:0]              tick;
    reg  [10:0]              mem_addr;
    reg                      replay_d;
    reg                      l1a_s1;
    reg                      l1a_s2;
    reg                      l1a_d;
    wire [31:0]              err_count;
    wire [127:0]             in_mem_data;
    wire [31:0]              out_mem_data;
    wire [7:0]               in_ptr;
    wire [7:0]               out_ptr;

    wire       bus_req   = WB_CYC_I & WB_STB_I;
    wire       bus_wr    = bus_req & WB_WE_I & WB_ACK_O;
    wire [5:0] reg_off   = WB_ADR_I[5:0];
    wire       wr_ctrl   = bus_wr & (reg_off == `TIEP_REG_CTRL);
    wire       wr_errcnt = bus_wr & (reg_off == `TIEP_REG_ERRCNT);
    wire       wr_errdet = bus_wr & (reg_off == `TIEP_REG_ERRDET);
    wire       wr_maddr  = bus_wr & (reg_off == `TIEP_REG_MEMADDR);
    wire       wr_mdata  = bus_wr & (reg_off == `TIEP_REG_MEMDATA);
    wire       replay    = ctrl[`TIEP_CTRL_REPLAY];
    wire       out_replay = replay & ctrl[`TIEP_CTRL_OUTMEM]; // [R17]
    wire       replay_start = replay & ~replay_d;

    // ****************************************
    // Error detection
    // ****************************************
    reg [NCH-1:0] crc_err;
    reg [NCH-1:0] ch_err;
    integer k;
    always @* begin
        crc_err = {NCH{1'b0}};
        for (k = 0; k < NCH; k = k + 1) begin
            crc_err[k] = crc8(RX_DATA[k*CW +: CW]) != RX_CRC[k*8 +: 8]; // [R2]
        end
        ch_err = RX_LINK_ERR | RX_CODE_ERR | crc_err; // [R1]
    end

    // Replay ignores the links, so their errors do not count then
    wire [NCH-1:0] live_err = replay ? {NCH{1'b0}} : ch_err;
    wire           any_err  = |live_err;
    wire [1:0]     unit_err_now = {|live_err[3:2], |live_err[1:0]};

    tiep_err_cnt u_err_cnt (
        .clk   (CLK),
        .nrst  (NRST),
        .clear (wr_errcnt),
        .inc   (any_err),
        .count (err_count)
    );

    // ****************************************
    // Scrolling memories
    // ****************************************
    tiep_scroll_mem #(.WIDTH(INW)) u_in_mem (
        .clk     (CLK),
        .nrst    (NRST),
        .wr_en   (wr_mdata),
        .wr_addr (mem_addr[7:0]),
        .wr_lane (mem_addr[10:8]),
        .wr_data (WB_DAT_I),
        .restart (replay_start),
        .advance (replay),
        .rd_data (in_mem_data),
        .rd_ptr  (in_ptr)
    );

    tiep_scroll_mem #(.WIDTH(32)) u_out_mem (
        .clk     (CLK),
        .nrst    (NRST),
        .wr_en   (wr_mdata & (mem_addr[10:8] == `TIEP_LANE_OUT)),
        .wr_addr (mem_addr[7:0]),
        .wr_lane (3'h0),
        .wr_data (WB_DAT_I),
        .restart (replay_start),
        .advance (out_replay),
        .rd_data (out_mem_data),
        .rd_ptr  (out_ptr)
    );

    // ****************************************
    // Register bus slave
    // ****************************************
    always @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= 32'h00000000;
        end else begin
            WB_ACK_O <= bus_req & ~WB_ACK_O;
            WB_DAT_O <= 32'h00000000;
            if (bus_req & ~WB_ACK_O & ~WB_WE_I) begin
                case (reg_off)
                    `TIEP_REG_CTRL:    WB_DAT_O <= {25'h0000000, ctrl};
                    `TIEP_REG_STATUS:  WB_DAT_O <= {14'h0000, out_ptr, in_ptr,
                                                    out_replay, replay}; // [R19]
                    `TIEP_REG_ERRCNT:  WB_DAT_O <= err_count; // [R21]
                    `TIEP_REG_ERRDET:  WB_DAT_O <= {20'h00000, err_det}; // [R4]
                    `TIEP_REG_ERRTICK: WB_DAT_O <= err_tick; // [R4]
                    `TIEP_REG_MEMADDR: WB_DAT_O <= {21'h000000, mem_addr};
                    default:           WB_DAT_O <= 32'h00000000;
                endcase
            end
        end
    end

    always @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            ctrl     <= `TIEP_CTRL_RESET;
            mem_addr <= 11'h000;
            replay_d <= 1'b0;
        end else begin
            replay_d <= replay;
            if (wr_ctrl && WB_SEL_I[0]) begin
                ctrl <= WB_DAT_I[`TIEP_CTRL_W-1:0]; // [R18] [R19]
            end
            if (wr_maddr) begin
                mem_addr <= WB_DAT_I[10:0];
            end
        end
    end

    // ****************************************
    // Error details, set wins over clear
    // ****************************************
    always @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            err_det  <= 12'h000;
            err_tick <= 32'h00000000;
            tick     <= 32'h00000000;
        end else begin
            tick <= tick + 32'h00000001;
            err_det <= (err_det & ~(wr_errdet ? WB_DAT_I[11:0] : 12'h000))
                       | (replay ? 12'h000
                                 : {crc_err, RX_CODE_ERR, RX_LINK_ERR}); // [R4]
            if (any_err) begin
                err_tick <= tick; // [R4]
            end
        end
    end

    // ****************************************
    // Algorithm input and real-time output
    // ****************************************
    always @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            ALG_IN_DATA   <= {INW{1'b0}};
            UNIT_ERR      <= 2'h0;
            CTP_OUT       <= {`TIEP_OUT_W{1'b0}};
            QUAD_RATE_SEL <= 1'b0;
        end else begin
            QUAD_RATE_SEL <= ctrl[`TIEP_CTRL_RATE]; // [R6]
            UNIT_ERR      <= unit_err_now;
            if (replay) begin
                ALG_IN_DATA <= in_mem_data; // [R14] [R15] [R17]
            end else begin
                // Each unit zeroes only its own pair of channels
                ALG_IN_DATA[2*CW-1:0] <= unit_err_now[0] ? {2*CW{1'b0}}
                                                         : RX_DATA[2*CW-1:0]; // [R5] [R7]
                ALG_IN_DATA[INW-1:2*CW] <= unit_err_now[1] ? {2*CW{1'b0}}
                                                           : RX_DATA[INW-1:2*CW]; // [R5] [R7]
            end
            if (out_replay) begin
                CTP_OUT <= out_mem_data; // [R16]
            end else begin
                CTP_OUT <= {ALG_OVERFLOW, ALG_PASS}; // [R8] [R9]
            end
        end
    end

    // ****************************************
    // Level-1 accept synchroniser
    // ****************************************
    always @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            l1a_s1 <= 1'b0;
            l1a_s2 <= 1'b0;
            l1a_d  <= 1'b0;
        end else begin
            l1a_s1 <= LEVEL1_ACCEPT; // [R13]
            l1a_s2 <= l1a_s1;
            l1a_d  <= l1a_s2;
        end
    end
    wire l1a = l1a_s2 & ~l1a_d;

    // ****************************************
    // Readout history and snapshot
    // ****************************************
    reg [31:0]  hist_out [0:2];
    reg [INW-1:0] hist_in [0:2];
    reg [2:0]   hist_err;
    reg [31:0]  snap_out [0:2];
    reg [INW-1:0] snap_in [0:2];
    reg         state;
    reg [1:0]   nslice;
    reg [1:0]   slice;
    reg [2:0]   word;
    reg         cap_in;
    integer j;

    wire [1:0] want = clamp_slices(ctrl[`TIEP_CTRL_SLC_HI:`TIEP_CTRL_SLC_LO]); // [R12]
    wire [2:0] want_mask = (want == 2'h1) ? 3'h1 : (want == 2'h2) ? 3'h3 : 3'h7;
    wire       err_seen  = |(hist_err & want_mask);
    wire       cap_now   = ctrl[`TIEP_CTRL_COND] ? err_seen
                                                 : ctrl[`TIEP_CTRL_INFIX]; // [R11]
    wire [2:0] last_word = cap_in ? 3'h4 : 3'h0;
    wire       at_end    = (slice == nslice - 2'h1) && (word == last_word);

    always @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            for (j = 0; j < 3; j = j + 1) begin
                hist_out[j] <= 32'h00000000;
                hist_in[j]  <= {INW{1'b0}};
                snap_out[j] <= 32'h00000000;
                snap_in[j]  <= {INW{1'b0}};
            end
            hist_err <= 3'h0;
        end else begin
            hist_out[0] <= CTP_OUT;
            hist_in[0]  <= ALG_IN_DATA;
            hist_err    <= {hist_err[1:0], |UNIT_ERR};
            for (j = 1; j < 3; j = j + 1) begin
                hist_out[j] <= hist_out[j-1];
                hist_in[j]  <= hist_in[j-1];
            end
            if (l1a && state == S_IDLE) begin
                for (j = 0; j < 3; j = j + 1) begin
                    snap_out[j] <= hist_out[j]; // [R10]
                    snap_in[j]  <= hist_in[j];
                end
            end
        end
    end

    // ****************************************
    // Readout sequencer
    // ****************************************
    always @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            state         <= S_IDLE;
            nslice        <= 2'h1;
            slice         <= 2'h0;
            word          <= 3'h0;
            cap_in        <= 1'b0;
            READOUT_DATA  <= 32'h00000000;
            READOUT_VALID <= 1'b0;
            READOUT_LAST  <= 1'b0;
        end else begin
            READOUT_VALID <= 1'b0;
            READOUT_LAST  <= 1'b0;
            case (state)
                S_IDLE: begin
                    if (l1a) begin
                        state  <= S_SEND;
                        nslice <= want;
                        cap_in <= cap_now;
                        slice  <= 2'h0;
                        word   <= 3'h0;
                    end
                end
                S_SEND: begin
                    READOUT_VALID <= 1'b1;
                    READOUT_LAST  <= at_end;
                    if (word == 3'h0) begin
                        READOUT_DATA <= snap_out[slice]; // [R10]
                    end else begin
                        READOUT_DATA <= snap_in[slice][(word-3'h1)*CW +: CW]; // [R11]
                    end
                    if (at_end) begin
                        state <= S_IDLE;
                    end else if (word == last_word) begin
                        word  <= 3'h0;
                        slice <= slice + 2'h1; // [R12]
                    end else begin
                        word <= word + 3'h1;
                    end
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end
endmodule

/* File: sim/tiep_chk_sva.sv */
`timescale 1ns/1ps
// ***
// Port checker
// ***
module tiep_chk (
    input wire logic         CLK,
    input wire logic         NRST,
    input wire logic [31:0]  WB_ADR_I,
    input wire logic [31:0]  WB_DAT_I,
    input wire logic [3:0]   WB_SEL_I,
    input wire logic         WB_WE_I,
    input wire logic         WB_CYC_I,
    input wire logic         WB_STB_I,
    input wire logic [31:0]  WB_DAT_O,
    input wire logic         WB_ACK_O,
    input wire logic [127:0] RX_DATA,
    input wire logic [3:0]   RX_LINK_ERR,
    input wire logic [3:0]   RX_CODE_ERR,
    input wire logic [127:0] ALG_IN_DATA,
    input wire logic [1:0]   UNIT_ERR,
    input wire logic [30:0]  ALG_PASS,
    input wire logic         ALG_OVERFLOW,
    input wire logic [31:0]  CTP_OUT,
    input wire logic         READOUT_VALID,
    input wire logic         READOUT_LAST
);
    logic [6:0] ctrl;
    logic [1:0] alive;
    logic       ok;
    logic       om;
    assign ok = (alive == 2'h3);
    assign om = ctrl[1] & ctrl[0];
    // Shadow of the control register, seen from the bus
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            ctrl <= 7'h10;
            alive <= 2'h0;
        end else begin
            if (alive != 2'h3) alive <= alive + 2'h1;
            if (WB_ACK_O && WB_CYC_I && WB_STB_I && WB_WE_I && WB_ADR_I[5:0] == 6'h00
                && WB_SEL_I[0]) ctrl <= WB_DAT_I[6:0];
        end
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (!NRST);
    a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack longer than one cycle");
    a_ack_answer: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
        else $error("no ack");
    a_dat_idle: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0)
        else $error("read data outside ack");
    a_ctp_direct: assert property (ok && !$past(om)
        |-> CTP_OUT == $past({ALG_OVERFLOW, ALG_PASS}))
        else $error("result word wrong");
    a_unit0_err: assert property (ok && !ctrl[0] && (|RX_LINK_ERR[1:0] || |RX_CODE_ERR[1:0])
        |=> UNIT_ERR[0])
        else $error("unit0 error missed");
    a_unit1_err: assert property (ok && !ctrl[0] && (|RX_LINK_ERR[3:2] || |RX_CODE_ERR[3:2])
        |=> UNIT_ERR[1])
        else $error("unit1 error missed");
    a_zero_bad: assert property (ok && !$past(ctrl[0]) && UNIT_ERR[0]
        |-> ALG_IN_DATA[63:0] == 64'h0)
        else $error("bad data not zeroed");
    a_clean_pass: assert property (ok && !ctrl[0] ##1 !UNIT_ERR[1]
        |-> ALG_IN_DATA[127:64] == $past(RX_DATA[127:64]))
        else $error("clean data altered");
    a_ro_single: assert property (ok && ctrl[5:4] <= 2'h1 && ctrl[3:2] == 2'h0
        && $rose(READOUT_VALID) |-> READOUT_LAST)
        else $error("single word readout not last");
    a_ro_end: assert property (ok && $fell(READOUT_VALID) |-> $past(READOUT_LAST))
        else $error("readout ended without last");
    cover property (ok && UNIT_ERR == 2'h3);
    cover property (ok && om);
    cover property (ok && READOUT_VALID && !READOUT_LAST);
endmodule

bind tiep_top tiep_chk i_tiep_chk (.CLK(CLK), .NRST(NRST), .WB_ADR_I(WB_ADR_I),
    .WB_DAT_I(WB_DAT_I), .WB_SEL_I(WB_SEL_I), .WB_WE_I(WB_WE_I), .WB_CYC_I(WB_CYC_I),
    .WB_STB_I(WB_STB_I),
    .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .RX_DATA(RX_DATA), .RX_LINK_ERR(RX_LINK_ERR),
    .RX_CODE_ERR(RX_CODE_ERR), .ALG_IN_DATA(ALG_IN_DATA), .UNIT_ERR(UNIT_ERR),
    .ALG_PASS(ALG_PASS), .ALG_OVERFLOW(ALG_OVERFLOW), .CTP_OUT(CTP_OUT),
    .READOUT_VALID(READOUT_VALID), .READOUT_LAST(READOUT_LAST));

/* File: sim/tiep_far_end.sv */
`timescale 1ns/1ps
// ***
// Upstream sources and algorithm result source
// ***
module tiep_far_end (
    input  wire logic [0:0] clk,
    input  wire logic [3:0] bad_crc,
    input  wire logic [3:0] link_in,
    input  wire logic [3:0] code_in,
    output logic [127:0]    rx_data = 128'h0,
    output logic [31:0]     rx_crc = 32'h0,
    output logic [3:0]      link_err = 4'h0,
    output logic [3:0]      code_err = 4'h0,
    output logic [30:0]     alg_pass = 31'h0,
    output logic            alg_ovf = 1'b0
);
    logic [7:0]  t = 8'h0;
    logic [31:0] w;
    function automatic logic [7:0] crc8(input logic [31:0] d);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 31; i >= 0; i--) begin
            c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
        end
        return c;
    endfunction
    // New word on every channel each tick
    always @(posedge clk) begin
        t <= t + 8'h01;
        link_err <= link_in;
        code_err <= code_in;
        alg_pass <= {t[6:0], ~t, t, t};
        alg_ovf <= t[0];
        for (int k = 0; k < 4; k++) begin
            w = {t, 8'(k), ~t, 8'h5A};
            rx_data[32*k +: 32] <= w;
            rx_crc[8*k +: 8] <= crc8(w) ^ {7'h0, bad_crc[k]};
        end
    end
endmodule

/* File: sim/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    logic         clk = 1'b0;
    logic         nrst = 1'b0;
    logic [31:0]  adr = 32'h0;
    logic [31:0]  wdat = 32'h0;
    logic         we = 1'b0;
    logic         cyc = 1'b0;
    logic         stb = 1'b0;
    logic         l1a = 1'b0;
    logic [3:0]   bad = 4'h0;
    logic [3:0]   lerr = 4'h0;
    logic [3:0]   cerr = 4'h0;
    wire  [31:0]  rdat, crc, central_trigger_processor, ro_data;
    wire  [127:0] rxd, alg_in;
    wire  [3:0]   le, ce;
    wire  [30:0]  pass;
    wire  [1:0]   unit_err;
    wire          ack, rate, ovf, ro_valid, ro_last;
    int           err_count = 0;
    int           tests_run = 0;
    int           ncyc = 0;
    logic [31:0]  q;
    logic [127:0] a;
    logic [7:0]   p;
    always #10 clk = ~clk;
    tiep_top i_tiep_top (.CLK(clk), .NRST(nrst), .WB_ADR_I(adr), .WB_DAT_I(wdat),
        .WB_SEL_I(4'hF), .WB_WE_I(we), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_DAT_O(rdat),
        .WB_ACK_O(ack), .RX_DATA(rxd), .RX_CRC(crc), .RX_LINK_ERR(le), .RX_CODE_ERR(ce),
        .QUAD_RATE_SEL(rate), .ALG_IN_DATA(alg_in), .UNIT_ERR(unit_err), .ALG_PASS(pass),
        .ALG_OVERFLOW(ovf), .CTP_OUT(central_trigger_processor), .LEVEL1_ACCEPT(l1a), .READOUT_DATA(ro_data),
        .READOUT_VALID(ro_valid), .READOUT_LAST(ro_last));
    tiep_far_end i_tiep_far_end (.clk(clk), .bad_crc(bad), .link_in(lerr), .code_in(cerr),
        .rx_data(rxd), .rx_crc(crc), .link_err(le), .code_err(ce), .alg_pass(pass),
        .alg_ovf(ovf));
    // ***
    // Tasks
    // ***
    task automatic wb(input logic w, input logic [5:0] ad, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {26'h0, ad};
        wdat <= d;
        do @(posedge clk); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %0t ns: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic rd(input logic [5:0] ad, input logic [31:0] e);
        wb(1'b0, ad, 32'h0);
        chk(q, e);
    endtask
    task automatic inject(input logic [3:0] b, input logic [3:0] l, input logic [3:0] c);
        @(posedge clk);
        bad <= b;
        lerr <= l;
        cerr <= c;
        @(posedge clk);
        bad <= 4'h0;
        lerr <= 4'h0;
        cerr <= 4'h0;
        repeat (4) @(posedge clk);
    endtask
    task automatic readout(input logic [31:0] c, input logic [31:0] n);
        logic [31:0] k;
        k = 32'h0;
        wb(1'b1, 6'h00, c);
        @(posedge clk);
        l1a <= 1'b1;
        repeat (2) @(posedge clk);
        l1a <= 1'b0;
        do begin
            @(posedge clk);
            if (ro_valid === 1'b1) k = k + 32'h1;
            if (k == 32'h1 && ro_valid === 1'b1)
                chk({16'h0, ro_data[23:8]}, {16'h0, ~ro_data[7:0], ro_data[7:0]});
        end while (ro_last !== 1'b1);
        chk(k, n);
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge clk) begin
        ncyc++;
        if (ncyc == 40000) begin
            err_count++;
            $display("[FAIL] %0t ns: timeout", $time);
            summarize();
        end
    end
    // ***
    // Tests
    // ***
    initial begin
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        chk({27'h0, ro_valid, ro_last, unit_err, rate}, 32'h0);
        rd(6'h00, 32'h10);
        rd(6'h08, 32'h0);
        rd(6'h3C, 32'h0);
        wb(1'b1, 6'h00, 32'h50);
        repeat (3) @(posedge clk);
        chk({31'h0, rate}, 32'h1);
        wb(1'b1, 6'h00, 32'h10);
        $display("test reset done");
        inject(4'h1, 4'h0, 4'h0);
        rd(6'h08, 32'h1);
        rd(6'h0C, 32'h100);
        wb(1'b1, 6'h0C, 32'hFFF);
        rd(6'h0C, 32'h0);
        inject(4'h4, 4'h2, 4'h8);
        rd(6'h08, 32'h2);
        rd(6'h0C, 32'h482);
        wb(1'b1, 6'h08, 32'h0);
        rd(6'h08, 32'h0);
        $display("test errors done");
        for (int i = 0; i < 256; i++) begin
            for (int k = 0; k < 5; k++) begin
                wb(1'b1, 6'h14, {21'h0, 3'(k), 8'(i)});
                wb(1'b1, 6'h18, (k == 4) ? {24'hC00000, 8'(i)}
                                         : {8'h10 + 8'(k), 16'h0, 8'(i)});
            end
        end
        wb(1'b1, 6'h00, 32'h13);
        wb(1'b0, 6'h04, 32'h0);
        chk({30'h0, q[1:0]}, 32'h3);
        chk({24'h0, q[17:10]}, {24'h0, q[9:2]});
        inject(4'h0, 4'hF, 4'hF);
        for (int j = 0; j < 300; j++) begin
            @(posedge clk);
            a = alg_in;
            chk(a[63:32], a[31:0] + 32'h0100_0000);
            chk(a[127:96], a[31:0] + 32'h0300_0000);
            chk({a[31:8], 8'h0}, 32'h1000_0000);
            chk({central_trigger_processor[31:8], 8'h0}, 32'hC000_0000);
            if (j > 0) chk({24'h0, a[7:0]}, {24'h0, p + 8'h01});
            p = a[7:0];
        end
        rd(6'h08, 32'h0);
        wb(1'b1, 6'h00, 32'h11);
        repeat (8) @(posedge clk);
        wb(1'b1, 6'h00, 32'h10);
        $display("test replay done");
        readout(32'h10, 32'd1);
        readout(32'h08, 32'd5);
        readout(32'h28, 32'd10);
        readout(32'h38, 32'd15);
        readout(32'h34, 32'd3);
        $display("test readout done");
        summarize();
    end
endmodule
